// File: logic/liuarm_regs.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
module liuarm_regs import liuarm_pkg::*; (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [15:0]       signal_absent_in,
  input  wire logic [15:0]       driver_fault_in,
  output logic                   irq,
  output logic [1:0]             soft_reset_active,
  output logic [1:0]             tester_system_side,
  output liuarm_clk_t [1:0]      tester_clock_source,
  output logic [1:0]             monitor_transmitter,
  output logic [1:0][7:0]        monitor_route
);

  typedef struct packed {
    logic [15:0]           sa_s1;
    logic [15:0]           sa_s2;
    logic [15:0]           sa_s3;
    logic [15:0]           sa_filt;
    logic [15:0]           df_s1;
    logic [15:0]           df_s2;
    logic [15:0]           df_s3;
    logic [15:0]           df_filt;
    logic [1:0][7:0]       sa_ie;
    logic [1:0][7:0]       df_ie;
    logic [1:0][7:0]       sa_is;
    logic [1:0][7:0]       df_is;
    logic [1:0][7:0]       ctrl;
    logic [1:0][7:0]       rst_cnt;
    logic [7:0]            bank_ptr;
    liuarm_phase_t         phase;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic                  irq;
    logic [1:0]            srst;
    logic [1:0]            tdir;
    liuarm_clk_t [1:0]     system_transmit_clock;
    logic [1:0]            mon_tx;
    logic [1:0][7:0]       mon_route;
  } liuarm_state_t;

  liuarm_state_t st;
  liuarm_state_t next_st;

  logic [15:0] chg_sa;
  logic [15:0] chg_df;
  logic        acc_done;
  logic [5:0]  idx;
  logic        grp;
  logic [7:0]  rd_val;
  logic        rd_ok;
  logic [2:0]  mon_code;

  // Register read decode, low five bits pick the register, bit 5 the group
  always_comb begin
    idx    = paddr[7:2];
    grp    = idx[5];
    rd_val = 8'h00;
    rd_ok  = 1'b1;
    case (idx[4:0])
      IDX_SIG_ABS_STAT_LO[4:0]: begin
        rd_val = st.sa_filt[grp*8 +: 8];
      end
      IDX_DRV_FLT_STAT_LO[4:0]: begin
        rd_val = st.df_filt[grp*8 +: 8];
      end
      IDX_SIG_ABS_IE_LO[4:0]: begin
        rd_val = st.sa_ie[grp];
      end
      IDX_DRV_FLT_IE_LO[4:0]: begin
        rd_val = st.df_ie[grp];
      end
      IDX_SIG_ABS_IS_LO[4:0]: begin
        rd_val = st.sa_is[grp];
      end
      IDX_DRV_FLT_IS_LO[4:0]: begin
        rd_val = st.df_is[grp];
      end
      IDX_SOFT_RST_LO[4:0]: begin
        rd_val = 8'h00;
      end
      IDX_TST_MON_LO[4:0]: begin
        rd_val = st.ctrl[grp];
      end
      IDX_BANK_PTR_LO[4:0]: begin
        rd_val = st.bank_ptr;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
    // Other banks selected: only the pointer answers
    if (st.bank_ptr != 8'h00 && idx[4:0] != IDX_BANK_PTR_LO[4:0]) begin
      rd_val = 8'h00;
    end
  end

  // Next-state logic
  always_comb begin
    next_st  = st;
    acc_done = psel && penable && st.pready;
    mon_code = 3'b000;
    // Pin synchronisers
    next_st.sa_s1 = signal_absent_in;
    next_st.sa_s2 = st.sa_s1;
    next_st.sa_s3 = st.sa_s2;
    next_st.df_s1 = driver_fault_in;
    next_st.df_s2 = st.df_s1;
    next_st.df_s3 = st.df_s2;
    // status follows once stages two and three agree
    next_st.sa_filt = (st.sa_filt & (st.sa_s2 ^ st.sa_s3))
                    | (st.sa_s3 & ~(st.sa_s2 ^ st.sa_s3));
    next_st.df_filt = (st.df_filt & (st.df_s2 ^ st.df_s3))
                    | (st.df_s3 & ~(st.df_s2 ^ st.df_s3));
    chg_sa = next_st.sa_filt ^ st.sa_filt;
    chg_df = next_st.df_filt ^ st.df_filt;

    // Bus slave: one wait state, answer presented in second access cycle
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.prdata  = 32'h0000_0000;
    next_st.phase   = LIUARM_IDLE;
    if (st.phase == LIUARM_IDLE && psel && penable) begin
      next_st.phase   = LIUARM_ANSWER;
      next_st.pready  = 1'b1;
      next_st.pslverr = ~rd_ok;
      next_st.prdata  = pwrite ? 32'h0000_0000 : {24'h000000, rd_val};
    end

    // Accesses take effect at the completing edge
    if (acc_done && !st.pslverr) begin
      if (pwrite) begin
        if (idx[4:0] == IDX_BANK_PTR_LO[4:0]) begin
          next_st.bank_ptr = pwdata[7:0];
        end else if (st.bank_ptr == 8'h00) begin
          case (idx[4:0])
            IDX_SIG_ABS_IE_LO[4:0]: begin
              next_st.sa_ie[grp] = pwdata[7:0];
            end
            IDX_DRV_FLT_IE_LO[4:0]: begin
              next_st.df_ie[grp] = pwdata[7:0];
            end
            IDX_SOFT_RST_LO[4:0]: begin
              next_st.rst_cnt[grp] = SRST_LOAD;
            end
            IDX_TST_MON_LO[4:0]: begin
              next_st.ctrl[grp] = pwdata[7:0] & TST_MON_MASK;
            end
            default: begin
            end
          endcase
        end
      end else if (st.bank_ptr == 8'h00) begin
        // clear only bits that were returned
        if (idx[4:0] == IDX_SIG_ABS_IS_LO[4:0]) begin
          next_st.sa_is[grp] = st.sa_is[grp] & ~st.prdata[7:0];
        end
        if (idx[4:0] == IDX_DRV_FLT_IS_LO[4:0]) begin
          next_st.df_is[grp] = st.df_is[grp] & ~st.prdata[7:0];
        end
      end
    end

    // enabled edges latch, set beats clear
    next_st.sa_is = next_st.sa_is | (chg_sa & st.sa_ie);
    next_st.df_is = next_st.df_is | (chg_df & st.df_ie);

    // Group soft reset countdown and forcing to defaults
    for (int g = 0; g < 2; g++) begin
      if (st.rst_cnt[g] != 8'h00 && next_st.rst_cnt[g] == st.rst_cnt[g]) begin
        next_st.rst_cnt[g] = st.rst_cnt[g] - 8'h01;
      end
      if (next_st.rst_cnt[g] != 8'h00) begin
        next_st.sa_ie[g] = REG_RESET;
        next_st.df_ie[g] = REG_RESET;
        next_st.sa_is[g] = REG_RESET;
        next_st.df_is[g] = REG_RESET;
        next_st.ctrl[g]  = REG_RESET;
      end
      next_st.srst[g] = next_st.rst_cnt[g] != 8'h00;
    end

    // Decoded tester and monitor controls, registered from control bits
    for (int g = 0; g < 2; g++) begin
      next_st.tdir[g] = st.ctrl[g][TST_DIR_BIT];
      if (st.ctrl[g][TST_DIR_BIT] && st.ctrl[g][TST_SYSTEM_TRANSMIT_CLOCK_BIT]) begin
        next_st.system_transmit_clock[g] = LIUARM_CLK_TRANSMIT;
      end else if (st.ctrl[g][TST_DIR_BIT] && st.ctrl[g][TST_MCLK_BIT]) begin
        next_st.system_transmit_clock[g] = LIUARM_CLK_MASTER;
      end else begin
        next_st.system_transmit_clock[g] = LIUARM_CLK_RECOVERED;
      end
      // route chosen line to first receiver
      mon_code = st.ctrl[g][2:0];
      next_st.mon_route[g] = 8'h00;
      if (mon_code != 3'b000) begin
        next_st.mon_route[g][mon_code] = 1'b1;
      end
      next_st.mon_tx[g] = st.ctrl[g][MON_TX_BIT] && (mon_code != 3'b000);
    end

    // interrupt while any event bit stands
    next_st.irq = (|next_st.sa_is) || (|next_st.df_is);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign prdata              = st.prdata;
  assign pready              = st.pready;
  assign pslverr             = st.pslverr;
  assign irq                 = st.irq;
  assign soft_reset_active   = st.srst;
  assign tester_system_side  = st.tdir;
  assign tester_clock_source = st.system_transmit_clock;
  assign monitor_transmitter = st.mon_tx;
  assign monitor_route       = st.mon_route;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence wr_rst_lo_s;
    acc_done && pwrite && idx == IDX_SOFT_RST_LO && st.bank_ptr == 8'h00;
  endsequence
  sequence wr_rst_hi_s;
    acc_done && pwrite && idx == IDX_SOFT_RST_HI && st.bank_ptr == 8'h00;
  endsequence
  sequence rd_is_lo_s;
    acc_done && !pwrite && idx == IDX_SIG_ABS_IS_LO
      && st.bank_ptr == 8'h00 && next_st.rst_cnt[0] == 8'h00;
  endsequence

  sa_status_agree_a: assert property (
    (st.sa_s2 == st.sa_s3) |=> (st.sa_filt == $past(st.sa_s3)))
    else $error("signal-absent status did not follow input");
  df_status_agree_a: assert property (
    (st.df_s2 == st.df_s3) |=> (st.df_filt == $past(st.df_s3)))
    else $error("driver-fault status did not follow input");
  sa_edge_latch_a: assert property (
    (|(chg_sa & st.sa_ie)) && next_st.rst_cnt == 16'h0000
      |=> ((st.sa_is & $past(chg_sa & st.sa_ie)) == $past(chg_sa & st.sa_ie)))
    else $error("enabled signal-absent edge not latched");
  sa_gate_en_a: assert property (
    (st.sa_is & ~$past(st.sa_is) & ~$past(chg_sa & st.sa_ie)) == 16'h0000)
    else $error("signal-absent event set without enabled edge");
  df_edge_latch_a: assert property (
    (|(chg_df & st.df_ie)) && next_st.rst_cnt == 16'h0000
      |=> ((st.df_is & $past(chg_df & st.df_ie)) == $past(chg_df & st.df_ie)))
    else $error("enabled driver-fault edge not latched");
  df_gate_en_a: assert property (
    (st.df_is & ~$past(st.df_is) & ~$past(chg_df & st.df_ie)) == 16'h0000)
    else $error("driver-fault event set without enabled edge");
  sa_read_clear_a: assert property (
    rd_is_lo_s |=> ((st.sa_is[0] & $past(st.prdata[7:0])
      & ~$past(chg_sa[7:0] & st.sa_ie[0])) == 8'h00))
    else $error("signal-absent event not cleared by read");
  srst_lo_hold_a: assert property (
    wr_rst_lo_s |=> (soft_reset_active[0] && st.ctrl[0] == 8'h00)[*8]
      ##192 soft_reset_active[0])
    else $error("lower soft reset shorter than one microsecond");
  srst_hi_hold_a: assert property (
    wr_rst_hi_s |=> (soft_reset_active[1] && st.sa_ie[1] == 8'h00)
      ##199 soft_reset_active[1])
    else $error("upper soft reset shorter than one microsecond");
  srst_read_zero_a: assert property (
    st.phase == LIUARM_ANSWER && !pwrite && idx[4:0] == IDX_SOFT_RST_LO[4:0]
      |-> prdata == 32'h0000_0000)
    else $error("soft reset register read not zero");
  tester_side_a: assert property (
    ##1 tester_system_side == {$past(st.ctrl[1][TST_DIR_BIT]),
                               $past(st.ctrl[0][TST_DIR_BIT])})
    else $error("tester side does not follow direction bit");
  system_transmit_clock_master_a: assert property (
    st.ctrl[0][7:5] == 3'b110 |=> tester_clock_source[0] == LIUARM_CLK_MASTER)
    else $error("master clock not selected");
  system_transmit_clock_transmit_a: assert property (
    st.ctrl[1][TST_DIR_BIT] && st.ctrl[1][TST_SYSTEM_TRANSMIT_CLOCK_BIT]
      |=> tester_clock_source[1] == LIUARM_CLK_TRANSMIT)
    else $error("transmit clock does not override");
  system_transmit_clock_recovered_a: assert property (
    st.ctrl[0][6:5] == 2'b00
      |=> tester_clock_source[0] == LIUARM_CLK_RECOVERED)
    else $error("recovered clock not selected");
  mon_route_a: assert property (
    st.ctrl[0][2:0] != 3'b000 |=> monitor_route[0] ==
      8'(8'h01 << $past(st.ctrl[0][2:0])) && monitor_transmitter[0] ==
      $past(st.ctrl[0][MON_TX_BIT]))
    else $error("monitor selection decoded wrongly");
  mon_none_a: assert property (
    st.ctrl[1][2:0] == 3'b000 |=> monitor_route[1] == 8'h00
      && !monitor_transmitter[1])
    else $error("monitor active with code zero");
  irq_level_a: assert property (
    irq == ((|st.sa_is) || (|st.df_is)))
    else $error("interrupt disagrees with event bits");
  apb_answer_a: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not one cycle after access");

endmodule

// File: logic/liuarm_pkg.sv
// Notes on behaviour
// - Per channel, signal-absent status reads one while loss is seen.
// - Per channel, driver-fault status reads one during a driver fault.
// - Signal-absent enable bits let status changes raise an interrupt.
// - Driver-fault enable bits let status changes raise an interrupt.
// - Signal-absent event bit latches on either edge, clears on read.
// - Signal-absent event latching is qualified by its enable bit.
// - Driver-fault event bit latches on either edge, clears on read.
// - Driver-fault event latching is qualified by its enable bit.
// - Any lower reset write: channels 1-8 at defaults at least 1 us.
// - Any upper reset write: channels 9-16 at defaults at least 1 us.
// - Soft reset registers always read back as zero.
// - Direction bit set moves the group tester to the system side.
// - System side, master select: master clock unless tx select set.
// - System side, transmit select: transmit clock, overriding master.
// - Neither select bit set: tester runs on recovered receive clock.
// - Monitor select: top bit tx/rx, low code 0 none, 1-7 channels 2-8.
// - First lower receiver monitors the chosen line of channels 2-8.
// - Ninth receiver monitors chosen line of channels 10-16.
package liuarm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SIG_ABS_STAT_LO = 6'h04;
  localparam logic [5:0] IDX_DRV_FLT_STAT_LO = 6'h05;
  localparam logic [5:0] IDX_SIG_ABS_IE_LO   = 6'h06;
  localparam logic [5:0] IDX_DRV_FLT_IE_LO   = 6'h07;
  localparam logic [5:0] IDX_SIG_ABS_IS_LO   = 6'h08;
  localparam logic [5:0] IDX_DRV_FLT_IS_LO   = 6'h09;
  localparam logic [5:0] IDX_SOFT_RST_LO     = 6'h0A;
  localparam logic [5:0] IDX_TST_MON_LO      = 6'h0B;
  localparam logic [5:0] IDX_BANK_PTR_LO     = 6'h1F;
  localparam logic [5:0] IDX_SIG_ABS_STAT_HI = 6'h24;
  localparam logic [5:0] IDX_DRV_FLT_STAT_HI = 6'h25;
  localparam logic [5:0] IDX_SIG_ABS_IE_HI   = 6'h26;
  localparam logic [5:0] IDX_DRV_FLT_IE_HI   = 6'h27;
  localparam logic [5:0] IDX_SIG_ABS_IS_HI   = 6'h28;
  localparam logic [5:0] IDX_DRV_FLT_IS_HI   = 6'h29;
  localparam logic [5:0] IDX_SOFT_RST_HI     = 6'h2A;
  localparam logic [5:0] IDX_TST_MON_HI      = 6'h2B;
  localparam logic [5:0] IDX_BANK_PTR_HI     = 6'h3F;
  // Control register fields
  localparam int unsigned TST_DIR_BIT  = 7;
  localparam int unsigned TST_MCLK_BIT = 6;
  localparam int unsigned TST_SYSTEM_TRANSMIT_CLOCK_BIT = 5;
  localparam int unsigned MON_TX_BIT   = 3;
  localparam logic [7:0]  TST_MON_MASK = 8'hEF;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  // Soft reset timing
  localparam int unsigned CLK_PERIOD_PS     = 5000;
  localparam int unsigned SOFT_RESET_MIN_US = 1;
  localparam int unsigned SOFT_RESET_CYCLES =
    (SOFT_RESET_MIN_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0]  SRST_LOAD = 8'(SOFT_RESET_CYCLES);
  // Tester clock source
  typedef enum logic [1:0] {
    LIUARM_CLK_RECOVERED = 2'b00,
    LIUARM_CLK_MASTER    = 2'b01,
    LIUARM_CLK_TRANSMIT  = 2'b10
  } liuarm_clk_t;
  // Bus slave phase
  typedef enum logic [0:0] {
    LIUARM_IDLE   = 1'b0,
    LIUARM_ANSWER = 1'b1
  } liuarm_phase_t;
endpackage

// File: dv/liu_alarm_reset_monitor_regs_tb_top.sv
`timescale 1ns/1ps
module liu_alarm_reset_monitor_regs_tb_top;
  import liuarm_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [15:0]       signal_absent_in;
  logic [15:0]       driver_fault_in;
  logic              irq;
  logic [1:0]        soft_reset_active;
  logic [1:0]        tester_system_side;
  liuarm_clk_t [1:0] tester_clock_source;
  logic [1:0]        monitor_transmitter;
  logic [1:0][7:0]   monitor_route;
  int                num_errors;
  int                n_checks;
  int                cycles = 0;
  logic [7:0]        rd;
  logic              err;
  logic [7:0]        ctl [6] = '{8'h00, 8'h80, 8'hC0, 8'hA0, 8'hE0, 8'h60};

  liuarm_regs i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .signal_absent_in(signal_absent_in), .driver_fault_in(driver_fault_in),
    .irq(irq), .soft_reset_active(soft_reset_active),
    .tester_system_side(tester_system_side),
    .tester_clock_source(tester_clock_source),
    .monitor_transmitter(monitor_transmitter), .monitor_route(monitor_route)
  );

  // Clock generation
  // one clock, tx clock locked
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready
  task automatic xfer(input logic wr, input logic [5:0] idx,
                      input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the hang guard ends a lost one
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata[7:0];
    err = pslverr;
    chk({24'h000000, prdata[31:8]}, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rd_exp(input logic [5:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk({24'h000000, rd}, {24'h000000, exp});
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  // Main sequence
  initial begin
    logic [1:0] src;
    int         n;
    num_errors = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    signal_absent_in = 16'h0000;
    driver_fault_in = 16'h0000;
    wait_cyc(2);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    for (int g = 0; g < 2; g++) begin
      chk({30'h0, tester_clock_source[g]},
          {30'h0, LIUARM_CLK_RECOVERED});
      for (int i = 4; i < 12; i++) rd_exp(6'(i + 32 * g), 8'h00);
    end
    $display("test reset_defaults done");

    wr(IDX_SIG_ABS_IE_LO, 8'hA5);
    rd_exp(IDX_SIG_ABS_IE_LO, 8'hA5);
    wr(IDX_DRV_FLT_IE_HI, 8'h5A);
    rd_exp(IDX_DRV_FLT_IE_HI, 8'h5A);
    wr(IDX_TST_MON_HI, 8'hFF);
    rd_exp(IDX_TST_MON_HI, TST_MON_MASK);
    wr(IDX_DRV_FLT_STAT_LO, 8'hFF);
    rd_exp(IDX_DRV_FLT_STAT_LO, 8'h00);
    xfer(1'b0, 6'h10, 8'h00);
    chk({31'h0, err}, 32'h1);
    wr(IDX_BANK_PTR_LO, 8'h01);
    rd_exp(IDX_SIG_ABS_IE_LO, 8'h00);
    wr(IDX_BANK_PTR_LO, 8'h00);
    rd_exp(IDX_SIG_ABS_IE_LO, 8'hA5);
    $display("test access done");

    // Channel 1 enabled, channel 2 not
    signal_absent_in <= 16'h0003;
    wait_cyc(8);
    rd_exp(IDX_SIG_ABS_STAT_LO, 8'h03);
    chk({31'h0, irq}, 32'h1);
    rd_exp(IDX_SIG_ABS_IS_LO, 8'h01);
    rd_exp(IDX_SIG_ABS_IS_LO, 8'h00);
    wait_cyc(3);
    chk({31'h0, irq}, 32'h0);
    signal_absent_in <= 16'h0000;
    wait_cyc(8);
    rd_exp(IDX_SIG_ABS_IS_LO, 8'h01);
    // Channel 10 enabled, channel 9 not
    driver_fault_in <= 16'h0300;
    wait_cyc(8);
    rd_exp(IDX_DRV_FLT_STAT_HI, 8'h03);
    rd_exp(IDX_DRV_FLT_IS_HI, 8'h02);
    rd_exp(IDX_DRV_FLT_IS_HI, 8'h00);
    driver_fault_in <= 16'h0000;
    wait_cyc(8);
    chk({31'h0, irq}, 32'h1);
    rd_exp(IDX_DRV_FLT_IS_HI, 8'h02);
    wait_cyc(3);
    chk({31'h0, irq}, 32'h0);
    $display("test events done");

    for (int g = 0; g < 2; g++) begin
      for (int k = 0; k < 6; k++) begin
        src = !ctl[k][7] ? 2'b00 : ctl[k][5] ? 2'b10
            : ctl[k][6] ? 2'b01 : 2'b00;
        wr(6'(IDX_TST_MON_LO + 32 * g), ctl[k]);
        wait_cyc(3);
        chk({31'h0, tester_system_side[g]}, {31'h0, ctl[k][7]});
        chk({30'h0, tester_clock_source[g]}, {30'h0, src});
      end
      for (int c = 0; c < 16; c++) begin
        wr(6'(IDX_TST_MON_LO + 32 * g), 8'(c));
        wait_cyc(3);
        chk({31'h0, monitor_transmitter[g]},
            {31'h0, c[3] && c[2:0] != 3'd0});
        chk({24'h0, monitor_route[g]},
            (c[2:0] == 3'd0) ? 32'h0 : (32'h1 << c[2:0]));
      end
    end
    $display("test tester_monitor done");

    wr(IDX_SIG_ABS_IE_LO, 8'hFF);
    wr(IDX_SIG_ABS_IE_HI, 8'hFF);
    wr(IDX_TST_MON_LO, 8'h8F);
    wr(IDX_SOFT_RST_LO, 8'h5C);
    wait_cyc(2);
    chk({30'h0, soft_reset_active}, 32'h1);
    rd_exp(IDX_SOFT_RST_LO, 8'h00);
    rd_exp(IDX_SIG_ABS_IE_LO, 8'h00);
    rd_exp(IDX_TST_MON_LO, 8'h00);
    rd_exp(IDX_SIG_ABS_IE_HI, 8'hFF);
    wr(IDX_SOFT_RST_HI, 8'h00);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (soft_reset_active[1] !== 1'b1 && n < 5);
    n = 0;
    while (soft_reset_active[1] === 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n >= 200}, 32'h1);
    rd_exp(IDX_SIG_ABS_IE_HI, 8'h00);
    rd_exp(IDX_SOFT_RST_HI, 8'h00);
    $display("test soft_reset done");
    end_sim();
  end
endmodule
